// File: verification/asrb_sva.sv
// Checker on the receiver outputs and the serial line
`timescale 1ns/1ns
module asrb_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serial_line,
  input wire logic port_enable,
  input wire logic continuous_receive_enable,
  input wire logic address_detect_enable,
  input wire logic nine_bit_receive_enable,
  input wire logic receive_interrupt_enable,
  input wire logic ninth_data_bit,
  input wire logic framing_error_flag,
  input wire logic overrun_error_flag,
  input wire logic receive_pending_flag,
  input wire logic receive_irq,
  input wire logic receive_idle_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Port shut down long enough for the outputs to follow
  sequence s_port_off;
    !port_enable [*2];
  endsequence
  // Buffer goes from empty to holding a character
  sequence s_load;
    $rose(receive_pending_flag);
  endsequence
  AST_IRQ_EN: assert property (
    receive_irq |-> $past(receive_interrupt_enable))
    else $error("irq raised without enable");
  AST_EMPTY_CLEAR: assert property (
    !receive_pending_flag |-> !ninth_data_bit && !framing_error_flag)
    else $error("status bits set with empty buffer");
  AST_OVR_CLEAR: assert property (
    !continuous_receive_enable |=> !overrun_error_flag)
    else $error("overrun kept with receive off");
  AST_OVR_FULL: assert property (
    $rose(overrun_error_flag) |-> receive_pending_flag)
    else $error("overrun with empty buffer");
  AST_ADDR_NINTH: assert property (
    address_detect_enable && $past(address_detect_enable) ##0 s_load
    |-> ninth_data_bit) else $error("address mode kept ninth bit zero");
  AST_EIGHT_BIT: assert property (
    !nine_bit_receive_enable ##0 s_load |-> !ninth_data_bit)
    else $error("ninth bit set in 8-bit mode");
  AST_PORT_OFF: assert property (
    s_port_off |=> !receive_pending_flag && !overrun_error_flag)
    else $error("buffer kept with port off");
  AST_OVR_HOLD: assert property (
    overrun_error_flag && $past(overrun_error_flag)
    |-> !$rose(receive_pending_flag)) else $error("load during overrun");
  AST_IDLE_START: assert property (
    $fell(receive_idle_flag) |-> !$past(serial_line, 2))
    else $error("idle dropped without start bit");
endmodule

// File: verification/async_serial_receiver_brg_test.sv
// Bench: transmitter end feeding the receiver end over the line
`timescale 1ns/1ns
module async_serial_receiver_brg_test import asrb_pkg::*;;
  logic clk_sys = 1'h0, rst = 1'h1, ce = 1'h1, sync_mode_select = 1'h0;
  logic port_enable = 1'h0, high_speed_select = 1'h1;
  logic wide_divisor_select = 1'h0, nine_bit_receive_enable = 1'h0;
  logic continuous_receive_enable = 1'h0, address_detect_enable = 1'h0;
  logic receive_interrupt_enable = 1'h0, divisor_low_wr = 1'h0;
  logic divisor_high_wr = 1'h0, data_read = 1'h0, nine_bit = 1'h1;
  logic stop_level = 1'h1, push_valid = 1'h0;
  logic [7:0] divisor_wr_data = 8'h00;
  logic [8:0] push_data = 9'h000;
  logic [15:0] bit_period = 16'h0010;
  logic [7:0] receive_data_register;
  logic ninth_data_bit, framing_error_flag, overrun_error_flag, tx_busy;
  logic receive_pending_flag, receive_irq, receive_idle_flag, push_ready;
  int n_fail = 0, num_checks = 0;
  asrb_if i_asrb_if ();
  asrb_rx i_asrb_rx (.clk_sys, .rst, .ce, .link(i_asrb_if.rx_end),
    .port_enable, .sync_mode_select, .high_speed_select,
    .wide_divisor_select, .nine_bit_receive_enable,
    .continuous_receive_enable, .address_detect_enable,
    .receive_interrupt_enable, .divisor_wr_data, .divisor_low_wr,
    .divisor_high_wr, .data_read, .receive_data_register, .ninth_data_bit,
    .framing_error_flag, .overrun_error_flag, .receive_pending_flag,
    .receive_irq, .receive_idle_flag);
  asrb_tx i_asrb_tx (.clk_sys, .rst, .ce, .link(i_asrb_if.tx_end),
    .bit_period, .nine_bit, .stop_level, .push_valid, .push_ready,
    .push_data, .tx_busy);
  asrb_sva i_asrb_sva (.clk_sys, .rst, .serial_line(i_asrb_if.serial_line),
    .port_enable, .continuous_receive_enable, .address_detect_enable,
    .nine_bit_receive_enable, .receive_interrupt_enable, .ninth_data_bit,
    .framing_error_flag, .overrun_error_flag, .receive_pending_flag,
    .receive_irq, .receive_idle_flag);
  // System clock, 4 ns period
  always #2 clk_sys = ~clk_sys;
  // Compare and count
  task automatic chk(string what, logic [8:0] seen, logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Divisor writes and rate selects; bp is the matching bit time
  task automatic setup(logic w, logic h, logic [15:0] n, logic [15:0] bp);
    @(negedge clk_sys);
    wide_divisor_select = w;
    high_speed_select = h;
    bit_period = bp;
    divisor_wr_data = n[7:0];
    divisor_low_wr = 1'h1;
    @(negedge clk_sys);
    divisor_low_wr = 1'h0;
    divisor_high_wr = 1'h1;
    divisor_wr_data = n[15:8];
    @(negedge clk_sys);
    divisor_high_wr = 1'h0;
  endtask
  // Push one word; ready seen at a falling edge holds to the next rise
  task automatic send(logic [8:0] w);
    @(negedge clk_sys);
    while (push_ready !== 1'h1) @(negedge clk_sys);
    push_valid = 1'h1;
    push_data = w;
    @(negedge clk_sys);
    push_valid = 1'h0;
  endtask
  // Wait until the transmitter has been quiet for a while
  task automatic drain();
    int q;
    q = 0;
    while (q < 40) begin
      @(negedge clk_sys);
      q = (tx_busy === 1'h1) ? 0 : q + 1;
    end
  endtask
  // Check the top character, then pop it
  task automatic rd(logic [8:0] exp, logic fe);
    chk("pending", receive_pending_flag, 9'h001);
    chk("data", {ninth_data_bit, receive_data_register}, exp);
    chk("framing", framing_error_flag, fe);
    data_read = 1'h1;
    @(negedge clk_sys);
    data_read = 1'h0;
    repeat (2) @(negedge clk_sys);
  endtask
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'h0;
    chk("idle", receive_idle_flag, 9'h001);
    setup(1'h0, 1'h1, 16'h0000, 16'h0010);
    port_enable = 1'h1;
    nine_bit_receive_enable = 1'h1;
    receive_interrupt_enable = 1'h1;
    @(negedge clk_sys);
    continuous_receive_enable = 1'h1;
    send(9'h1A5);
    repeat (20) @(negedge clk_sys);
    chk("busy", receive_idle_flag, 9'h000);
    drain();
    chk("irq", receive_irq, 9'h001);
    rd(9'h1A5, 1'h0);
    chk("empty", receive_pending_flag, 9'h000);
    receive_interrupt_enable = 1'h0;
    send(9'h05A);
    drain();
    chk("irq off", receive_irq, 9'h000);
    // Clock enable low freezes the buffer against a read
    ce = 1'h0;
    data_read = 1'h1;
    repeat (4) @(negedge clk_sys);
    data_read = 1'h0;
    ce = 1'h1;
    chk("frozen", receive_pending_flag, 9'h001);
    rd(9'h05A, 1'h0);
    // Bad stop bit on one character only
    stop_level = 1'h0;
    send(9'h133);
    drain();
    stop_level = 1'h1;
    send(9'h0CC);
    drain();
    rd(9'h133, 1'h1);
    rd(9'h0CC, 1'h0);
    // Port off clears a held framing error
    stop_level = 1'h0;
    send(9'h111);
    drain();
    stop_level = 1'h1;
    chk("framing_error_flag on", framing_error_flag, 9'h001);
    port_enable = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk("framing_error_flag off", framing_error_flag, 9'h000);
    port_enable = 1'h1;
    // 8-bit characters drop the ninth bit
    nine_bit_receive_enable = 1'h0;
    nine_bit = 1'h0;
    send(9'h17E);
    drain();
    rd(9'h07E, 1'h0);
    nine_bit_receive_enable = 1'h1;
    nine_bit = 1'h1;
    // Address mode keeps only marked characters
    address_detect_enable = 1'h1;
    send(9'h055);
    send(9'h1AB);
    drain();
    rd(9'h1AB, 1'h0);
    chk("dropped", receive_pending_flag, 9'h000);
    address_detect_enable = 1'h0;
    send(9'h033);
    drain();
    rd(9'h033, 1'h0);
    // Synchronous select keeps the receiver off
    sync_mode_select = 1'h1;
    send(9'h0F0);
    repeat (20) @(negedge clk_sys);
    chk("sync idle", receive_idle_flag, 9'h001);
    drain();
    chk("sync drop", receive_pending_flag, 9'h000);
    sync_mode_select = 1'h0;
    // Fill the FIFO until it refuses; receiver overruns
    for (int i = 0; i < 17; i++) send(9'h100 + 9'(i));
    chk("fifo full", push_ready, 9'h000);
    drain();
    chk("overrun", overrun_error_flag, 9'h001);
    rd(9'h100, 1'h0);
    rd(9'h101, 1'h0);
    chk("blocked", receive_pending_flag, 9'h000);
    continuous_receive_enable = 1'h0;
    repeat (2) @(negedge clk_sys);
    chk("ovr clear", overrun_error_flag, 9'h000);
    continuous_receive_enable = 1'h1;
    // Every async rate mode set to 64 clocks per bit
    for (int m = 0; m < 4; m++) begin
      setup(m[1], m[0], (m == 0) ? 16'h0000 : (m == 3) ? 16'h000F : 16'h0003,
        16'h0040);
      send(9'h0C3 + 9'(m));
      drain();
      rd(9'h0C3 + 9'(m), 1'h0);
    end
    stop_test();
  end
endmodule

// File: verilog/asrb_if.sv
// Serial line between the remote transmitter and the receiver
`timescale 1ns/1ns
interface asrb_if;
  logic serial_line;
  modport rx_end (input serial_line);
  modport tx_end (output serial_line);
endinterface

// File: verilog/asrb_pkg.sv
// Shared constants and state types for the serial receiver and its far end
package asrb_pkg;
  // Character and buffer shape
  localparam int CHAR_W = 9;
  localparam int RX_BUF_DEPTH = 2;
  localparam int TX_FIFO_DEPTH = 16;
  localparam logic [1:0] RX_BUF_FULL = 2'h2;
  // Oversampling positions within one bit (16 ticks per bit)
  localparam logic [3:0] OS_START_MID = 4'h8;
  localparam logic [3:0] OS_BIT_END = 4'hF;
  // Index of the last data bit for 9-bit and 8-bit characters
  localparam logic [3:0] LAST_BIT_NINE = 4'h8;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  // Divisor multipliers: x64 uses a 4-cycle prescale, x4 a step of 4
  localparam logic [1:0] PRESCALE_X64_LAST = 2'h3;
  localparam logic [16:0] STEP_X16 = 17'h00001;
  localparam logic [16:0] STEP_X4 = 17'h00004;
  // Reset values
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [2:0] SAMPLES_IDLE = 3'h7;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA,
    RX_STOP} asrb_rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA,
    TX_STOP} asrb_tx_state_t;
endpackage

// File: verilog/asrb_rx.sv
// Asynchronous receiver with baud rate generator and two-character buffer
//
// Behaviour
// - Pending flag on buffer load; interrupt needs enable
// - Status shows errors and top ninth bit
// - Data read returns low eight bits, pops
// - Clearing continuous receive clears overrun
// - Third character while two unread sets overrun
// - Address mode keeps only ninth-bit-one characters
// - Address mode characters report ninth bit one
// - Address mode off accepts every character
// - Software keeps async mode, enables port last
// - Software sets width, address mode, then receive
// - Free-running timer, 8 or 16 bits wide
// - Multiplier from high-speed and wide selects
// - Divisor write clears the baud timer
// - Async 8-bit normal speed: divide 64(n+1)
// - Async x16 modes: divide 16(n+1)
// - Synchronous mode: divide 4(n+1)
// - Receive idle flag provided for clock changes
// - Sixteen-times oversampling with majority vote
// - Recheck start at half bit, abort silently
// - Zero stop bit flags framing error per character
// - Two-character buffer; overrun blocks further characters
`timescale 1ns/1ns
module asrb_rx
  import asrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  asrb_if.rx_end link,
  input wire logic port_enable,
  input wire logic sync_mode_select,
  input wire logic high_speed_select,
  input wire logic wide_divisor_select,
  input wire logic nine_bit_receive_enable,
  input wire logic continuous_receive_enable,
  input wire logic address_detect_enable,
  input wire logic receive_interrupt_enable,
  input wire logic [7:0] divisor_wr_data,
  input wire logic divisor_low_wr,
  input wire logic divisor_high_wr,
  input wire logic data_read,
  output logic [7:0] receive_data_register,
  output logic ninth_data_bit,
  output logic framing_error_flag,
  output logic overrun_error_flag,
  output logic receive_pending_flag,
  output logic receive_irq,
  output logic receive_idle_flag
);
  logic [7:0] baud_divisor_low_q, baud_divisor_high_q, data_q;
  logic [1:0] pre_q, cnt_q, cnt_after;
  logic [16:0] acc_q, limit, step, sum;
  logic mode_x64, advance, tick, div_wr, maj, rx_on, char_done;
  logic line_m_q, line_s_q, line_prev_q;
  logic [2:0] samp_q, samp_n;
  asrb_rx_state_t state_q;
  logic [3:0] os_q, bit_q, last_bit;
  logic [8:0] rsr_q, char_word;
  logic [9:0] top, buf_q [RX_BUF_DEPTH];
  logic rd_q, pop, accept, push, ovr_q, ovr_set, wr_idx;
  logic ninth_q, framing_error_flag_q, pend_q, irq_q, idle_q;

  // Divisor register pair
  assign div_wr = divisor_low_wr | divisor_high_wr;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      baud_divisor_low_q <= DIVISOR_RESET;
      baud_divisor_high_q <= DIVISOR_RESET;
    end else if (ce) begin
      if (divisor_low_wr) begin
        baud_divisor_low_q <= divisor_wr_data;
      end
      if (divisor_high_wr) begin
        baud_divisor_high_q <= divisor_wr_data;
      end
    end
  end

  // Multiplier select: x64, x16 or x4 per bit of oversampling
  always_comb begin
    mode_x64 = ~sync_mode_select & ~wide_divisor_select & ~high_speed_select;
    if (sync_mode_select) begin
      step = STEP_X4;
    end else if (wide_divisor_select & high_speed_select) begin
      step = STEP_X4;
    end else begin
      step = STEP_X16;
    end
    if (wide_divisor_select) begin
      limit = {1'b0, baud_divisor_high_q, baud_divisor_low_q};
    end else begin
      limit = {9'h000, baud_divisor_low_q};
    end
  end
  assign advance = ~mode_x64 | (pre_q == PRESCALE_X64_LAST);
  assign sum = acc_q + step;
  assign tick = advance & (sum > limit);

  // Free-running baud timer, cleared by any divisor write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_q <= 2'h0;
      acc_q <= 17'h00000;
    end else if (ce) begin
      if (div_wr) begin
        pre_q <= 2'h0;
        acc_q <= 17'h00000;
      end else begin
        pre_q <= pre_q + 2'h1;
        if (tick) begin
          acc_q <= sum - limit - 17'h00001;
        end else if (advance) begin
          acc_q <= sum;
        end
      end
    end
  end

  // Line synchroniser and edge history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_m_q <= LINE_IDLE;
      line_s_q <= LINE_IDLE;
      line_prev_q <= LINE_IDLE;
      samp_q <= SAMPLES_IDLE;
    end else if (ce) begin
      line_m_q <= link.serial_line;
      line_s_q <= line_m_q;
      line_prev_q <= line_s_q;
      if (tick) begin
        samp_q <= samp_n;
      end
    end
  end
  assign samp_n = {samp_q[1:0], line_s_q};
  assign maj = (samp_n[0] & samp_n[1]) | (samp_n[0] & samp_n[2]) |
               (samp_n[1] & samp_n[2]);

  assign rx_on = port_enable & continuous_receive_enable & ~sync_mode_select;
  assign last_bit = nine_bit_receive_enable ? LAST_BIT_NINE : LAST_BIT_EIGHT;
  assign char_done = rx_on & (state_q == RX_STOP) & tick &
                     (os_q == OS_BIT_END);
  assign char_word = nine_bit_receive_enable ? rsr_q : {1'b0, rsr_q[8:1]};

  // Character recovery state machine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= RX_IDLE;
      os_q <= 4'h0;
      bit_q <= 4'h0;
      rsr_q <= 9'h000;
    end else if (ce) begin
      if (!rx_on) begin
        state_q <= RX_IDLE;
      end else begin
        unique case (state_q)
          RX_IDLE: begin
            if (line_prev_q & ~line_s_q) begin
              state_q <= RX_START;
              os_q <= 4'h0;
            end
          end
          RX_START: begin
            if (tick) begin
              os_q <= os_q + 4'h1;
              if (os_q == OS_START_MID) begin
                if (maj) begin
                  state_q <= RX_IDLE;
                end else begin
                  state_q <= RX_DATA;
                  os_q <= 4'h0;
                  bit_q <= 4'h0;
                end
              end
            end
          end
          RX_DATA: begin
            if (tick) begin
              os_q <= os_q + 4'h1;
              if (os_q == OS_BIT_END) begin
                rsr_q <= {maj, rsr_q[8:1]};
                bit_q <= bit_q + 4'h1;
                if (bit_q == last_bit) begin
                  state_q <= RX_STOP;
                end
              end
            end
          end
          RX_STOP: begin
            if (tick) begin
              os_q <= os_q + 4'h1;
              if (os_q == OS_BIT_END) begin
                state_q <= RX_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Buffer admission, pop and overrun
  assign pop = data_read & (cnt_q != 2'h0);
  assign cnt_after = cnt_q - {1'b0, pop};
  assign accept = char_done & ~ovr_q &
                  ~(address_detect_enable & ~char_word[8]);
  assign push = accept & (cnt_after != RX_BUF_FULL);
  assign ovr_set = accept & (cnt_after == RX_BUF_FULL);
  assign wr_idx = (rd_q ^ pop) ^ cnt_after[0];
  assign top = buf_q[rd_q];

  // Two-character buffer with per-character framing error
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      ovr_q <= 1'b0;
      buf_q[0] <= 10'h000;
      buf_q[1] <= 10'h000;
    end else if (ce) begin
      if (!port_enable) begin
        rd_q <= 1'b0;
        cnt_q <= 2'h0;
        ovr_q <= 1'b0;
        buf_q[0] <= 10'h000;
        buf_q[1] <= 10'h000;
      end else begin
        rd_q <= rd_q ^ pop;
        cnt_q <= cnt_after + {1'b0, push};
        if (push) begin
          buf_q[wr_idx] <= {~maj, char_word};
        end
        if (!continuous_receive_enable) begin
          ovr_q <= 1'b0;
        end else if (ovr_set) begin
          ovr_q <= 1'b1;
        end
      end
    end
  end

  // Status and data outputs from the top character
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_q <= 8'h00;
      ninth_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      pend_q <= 1'b0;
      irq_q <= 1'b0;
      idle_q <= 1'b1;
    end else if (ce) begin
      data_q <= top[7:0];
      ninth_q <= top[8] & (cnt_q != 2'h0);
      framing_error_flag_q <= top[9] & (cnt_q != 2'h0);
      pend_q <= (cnt_q != 2'h0);
      irq_q <= (cnt_q != 2'h0) & receive_interrupt_enable;
      idle_q <= (state_q == RX_IDLE);
    end
  end
  assign receive_data_register = data_q;
  assign ninth_data_bit = ninth_q;
  assign framing_error_flag = framing_error_flag_q;
  assign overrun_error_flag = ovr_q;
  assign receive_pending_flag = pend_q;
  assign receive_irq = irq_q;
  assign receive_idle_flag = idle_q;
endmodule

// File: verilog/asrb_tx.sv
// Remote transmitter end: word FIFO and serial framer
`timescale 1ns/1ns
module asrb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic in_ready_q;
  logic out_valid_q;
  logic wr;
  logic rd;

  assign wr = in_valid & in_ready_q;
  assign rd = out_ready & out_valid_q;
  assign cnt_d = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};

  // Pointers, fill level and honest full/empty
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end else if (ce) begin
      if (wr) begin
        wr_q <= wr_q + AW'(1);
      end
      if (rd) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != FULL);
      out_valid_q <= (cnt_d != '0);
    end
  end

  // Storage
  always_ff @(posedge clk_sys) begin
    if (ce && wr) begin
      mem[wr_q] <= in_data;
    end
  end
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem[rd_q];
endmodule

module asrb_tx
  import asrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  asrb_if.tx_end link,
  input wire logic [15:0] bit_period,
  input wire logic nine_bit,
  input wire logic stop_level,
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [8:0] push_data,
  output logic tx_busy
);
  asrb_tx_state_t state_q;
  logic [15:0] cnt_q;
  logic [3:0] bits_q;
  logic [8:0] sh_q;
  logic nine_q;
  logic line_q;
  logic busy_q;
  logic f_valid;
  logic f_ready;
  logic [8:0] f_data;
  logic bit_end;

  asrb_fifo #(.WIDTH(CHAR_W), .DEPTH(TX_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Drain only while the framer is idle
  assign f_ready = (state_q == TX_IDLE);
  assign bit_end = ({1'b0, cnt_q} + 17'h00001) >= {1'b0, bit_period};

  // Framer: start, 8 or 9 data bits LSB first, stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= TX_IDLE;
      cnt_q <= 16'h0000;
      bits_q <= 4'h0;
      sh_q <= 9'h000;
      nine_q <= 1'b0;
      line_q <= LINE_IDLE;
      busy_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= (bit_end || state_q == TX_IDLE) ? 16'h0000 : cnt_q + 16'h0001;
      unique case (state_q)
        TX_IDLE: begin
          if (f_valid) begin
            state_q <= TX_START;
            sh_q <= f_data;
            nine_q <= nine_bit;
            line_q <= 1'b0;
            busy_q <= 1'b1;
          end
        end
        TX_START: begin
          if (bit_end) begin
            state_q <= TX_DATA;
            line_q <= sh_q[0];
            sh_q <= {1'b0, sh_q[8:1]};
            bits_q <= 4'h0;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            if (bits_q == (nine_q ? LAST_BIT_NINE : LAST_BIT_EIGHT)) begin
              state_q <= TX_STOP;
              line_q <= stop_level;
            end else begin
              line_q <= sh_q[0];
              sh_q <= {1'b0, sh_q[8:1]};
              bits_q <= bits_q + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            state_q <= TX_IDLE;
            line_q <= LINE_IDLE;
            busy_q <= 1'b0;
          end
        end
      endcase
    end
  end
  assign link.serial_line = line_q;
  assign tx_busy = busy_q;
endmodule
